// ===== hw/clock_gating_map.svh
// Purpose: Offsets, field positions, reset values and mode codes of the peripheral clock gating block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Gating register keeps the documented bit layout in its low byte.
// Notes on behaviour
// - Set gate bit stops that peripheral clock.
// - Gated peripheral frozen, its registers blocked.
// - Ungating resumes peripheral in held state.
// - Bits 7,2,1 gate two-wire, SPI, USART.
// - Bit 6 gates second timer when synchronous.
// - Bits 5,3 gate first and wide timer.
// - Bit 4 reserved, reads zero.
// - Bit 0 gates converter; disable it first.
// - Gated converter denies comparator its multiplexer.
// - Gating acts only in active and idle, and for the converter in noise reduction.
// - Enabled converter stays enabled in sleep.
// - Converter restart forces extended first conversion.
// - Deep sleep disables comparator automatically.
// - Comparator on reference keeps reference in sleep.
// - Reference on when detector, comparator, converter need.
// - Reference restart needs start-up; kept one ready.
// - Fuse-enabled brown-out detector stays on in sleep.
// - Enabled watchdog stays active in sleep.
// - Buffers off when I/O and converter clocks stop.
// - Input disable registers switch buffers off always.
// - Debug fuse keeps main clock during sleep.
// - Idle stops only processor and program clocks.
`ifndef CLOCK_GATING_MAP_SVH
`define CLOCK_GATING_MAP_SVH

`define GATE_REG_ADDR      12'h000
`define CMP_DIS_REG_ADDR   12'h004
`define CNV_DIS_REG_ADDR   12'h008
`define STATUS_REG_ADDR    12'h00C
`define GATE_RESET         8'h00
`define GATE_WRITE_MASK    8'hEF
`define BIT_TWO_WIRE       7
`define BIT_TIMER2         6
`define BIT_TIMER0         5
`define BIT_RESERVED       4
`define BIT_TIMER1         3
`define BIT_SPI            2
`define BIT_USART          1
`define BIT_CONVERTER      0
`define NUM_UNITS          8
`define BOD_DISABLED       3'h7
`define SLEEP_IDLE         3'h0
`define SLEEP_NOISE        3'h1
`define REF_STARTUP_NS     70000
`define CLK_PERIOD_NS      8

`endif

// ===== hw/clock_gating_pkg.sv
// Purpose: Types of the peripheral clock gating block.
// Assumes: The map header is included alongside.
// Notes: Only types live here.
`default_nettype none
package clock_gating_pkg;
	typedef enum logic [1:0] {ref_off, ref_starting, ref_ready} ref_state_e;
	typedef struct packed {
		logic brownout_on;
		logic watchdog_on;
		logic converter_on;
		logic comparator_on;
		logic comparator_uses_ref;
	} analog_req_s;
endpackage : clock_gating_pkg
`default_nettype wire

// ===== hw/peripheral_clock_gating.sv
// Purpose: Per-peripheral clock gate enables, freeze and access blocking, sleep-time analog control.
// Assumes: Peripherals take a clock enable; freezing means holding every flop while the enable is low.
// Notes: Register access over APB, zero wait states, unmapped addresses answer with pslverr.
`include "clock_gating_map.svh"
`default_nettype none
module peripheral_clock_gating
	import clock_gating_pkg::*;
#(
	parameter int          REF_STARTUP_CYCLES = (`REF_STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int unsigned CMP_PINS           = 2,
	parameter int unsigned CNV_PINS           = 8
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                sleeping,
	input  wire logic [2:0]          sleep_mode_select,
	input  wire logic                timer_async_select,
	input  wire logic                debug_enable_fuse,
	input  wire logic [2:0]          brownout_level_fuse,
	input  wire analog_req_s         analog_req,
	input  wire logic [`NUM_UNITS-1:0] periph_access_req,
	input  wire logic [`NUM_UNITS-1:0] wake_pin_need,
	output logic      [`NUM_UNITS-1:0] unit_clock_en,
	output logic      [`NUM_UNITS-1:0] periph_access_ok,
	output logic                     cpu_clock_en,
	output logic                     io_clock_en,
	output logic                     converter_clock_en,
	output logic                     main_osc_en,
	output logic                     comparator_mux_allow,
	output logic                     comparator_en,
	output logic                     converter_en,
	output logic                     converter_extended,
	output logic                     watchdog_en,
	output logic                     brownout_en,
	output logic                     reference_en,
	output logic                     reference_ready,
	output logic      [CMP_PINS-1:0] comparator_input_disable,
	output logic      [CNV_PINS-1:0] converter_input_disable,
	output logic                     input_buffer_sleep_off,
	output logic      [`NUM_UNITS-1:0] wake_buffer_en
);

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0]          peripheral_clock_gate;
	logic [7:0]          next_peripheral_clock_gate;
	logic [CMP_PINS-1:0] next_cmp_dis;
	logic [CNV_PINS-1:0] next_cnv_dis;
	logic                wr;
	logic                hit;
	logic [7:0]          status;

	// Every check below runs on the bus clock and rests while reset is held.
	default clocking dcb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	function automatic logic sel(input logic [11:0] a, input logic [11:0] b);
		sel = (a == b);
	endfunction : sel

	assign wr     = psel && penable && pwrite;
	assign hit    = sel(paddr, `GATE_REG_ADDR) || sel(paddr, `CMP_DIS_REG_ADDR) ||
	                sel(paddr, `CNV_DIS_REG_ADDR) || sel(paddr, `STATUS_REG_ADDR);
	assign pready = 1'b1;

	always_comb begin
		next_peripheral_clock_gate = peripheral_clock_gate;
		next_cmp_dis               = comparator_input_disable;
		next_cnv_dis               = converter_input_disable;
		if (wr && sel(paddr, `GATE_REG_ADDR)) begin
			next_peripheral_clock_gate = pwdata[7:0] & `GATE_WRITE_MASK;
		end
		if (wr && sel(paddr, `CMP_DIS_REG_ADDR)) begin
			next_cmp_dis = pwdata[CMP_PINS-1:0];
		end
		if (wr && sel(paddr, `CNV_DIS_REG_ADDR)) begin
			next_cnv_dis = pwdata[CNV_PINS-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peripheral_clock_gate    <= `GATE_RESET;
			comparator_input_disable <= '0;
			converter_input_disable  <= '0;
		end else begin
			peripheral_clock_gate    <= next_peripheral_clock_gate;
			comparator_input_disable <= next_cmp_dis;
			converter_input_disable  <= next_cnv_dis;
		end
	end

	// Read data is registered so it stays stable into the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !hit;
			prdata  <= 32'h0000_0000;
			unique case (1'b1)
				sel(paddr, `GATE_REG_ADDR):    prdata <= {24'h00_0000, peripheral_clock_gate};
				sel(paddr, `CMP_DIS_REG_ADDR): prdata <= {{(32-CMP_PINS){1'b0}}, comparator_input_disable};
				sel(paddr, `CNV_DIS_REG_ADDR): prdata <= {{(32-CNV_PINS){1'b0}}, converter_input_disable};
				sel(paddr, `STATUS_REG_ADDR):  prdata <= {24'h00_0000, status};
				default:                       prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gating only matters while a unit's clock runs; deeper sleep stops the I/O clock, but noise reduction keeps the converter's.
	logic idle_sleep;
	logic noise_sleep;
	logic deep_sleep;

	assign idle_sleep   = sleeping && (sleep_mode_select == `SLEEP_IDLE);
	assign noise_sleep  = sleeping && (sleep_mode_select == `SLEEP_NOISE);
	assign deep_sleep   = sleeping && !idle_sleep && !noise_sleep;
	assign cpu_clock_en = !sleeping;
	assign io_clock_en  = !sleeping || idle_sleep;
	assign converter_clock_en = !sleeping || idle_sleep || noise_sleep;
	assign main_osc_en  = !deep_sleep || debug_enable_fuse;

	genvar g;
	generate
		for (g = 0; g < `NUM_UNITS; g++) begin : g_unit
			logic gated;
			if (g == `BIT_TIMER2) begin : g_t2
				assign gated = peripheral_clock_gate[g] && !timer_async_select;
			end else begin : g_other
				assign gated = peripheral_clock_gate[g];
			end
			// Holding the enable low freezes every flop, so ungating resumes where it stopped.
			assign unit_clock_en[g]    = !gated && (g == `BIT_CONVERTER ? converter_clock_en : io_clock_en);
			assign periph_access_ok[g] = periph_access_req[g] && !gated;
			assign wake_buffer_en[g]   = wake_pin_need[g];
		end
	endgenerate

	assign comparator_mux_allow   = !peripheral_clock_gate[`BIT_CONVERTER];
	assign input_buffer_sleep_off = sleeping && !io_clock_en && !converter_clock_en;

	////////////////////////////////////////////////////////////////////////////////
	assign comparator_en = analog_req.comparator_on && !deep_sleep;
	assign converter_en  = analog_req.converter_on;
	assign watchdog_en   = analog_req.watchdog_on;
	assign brownout_en   = (brownout_level_fuse != `BOD_DISABLED);
	// A comparator on the reference keeps the reference even in deep sleep.
	assign reference_en  = brownout_en || analog_req.converter_on ||
	                       (analog_req.comparator_on && analog_req.comparator_uses_ref);

	ref_state_e ref_state;
	ref_state_e next_ref_state;
	logic [31:0] ref_count;
	logic [31:0] next_ref_count;
	logic        conv_was_on;
	logic        next_conv_ext;

	always_comb begin
		next_ref_state = ref_state;
		next_ref_count = ref_count;
		unique case (ref_state)
			ref_off: begin
				next_ref_count = 32'h0000_0000;
				if (reference_en) begin
					next_ref_state = ref_starting;
				end
			end
			ref_starting: begin
				next_ref_count = ref_count + 32'h0000_0001;
				if (!reference_en) begin
					next_ref_state = ref_off;
				end else if (ref_count >= 32'(REF_STARTUP_CYCLES - 1)) begin
					next_ref_state = ref_ready;
				end
			end
			ref_ready: begin
				if (!reference_en) begin
					next_ref_state = ref_off;
				end
			end
		endcase
		next_conv_ext = converter_extended;
		if (analog_req.converter_on && !conv_was_on) begin
			next_conv_ext = 1'b1;
		end else if (!analog_req.converter_on) begin
			next_conv_ext = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_state          <= ref_off;
			ref_count          <= 32'h0000_0000;
			conv_was_on        <= 1'b0;
			converter_extended <= 1'b0;
		end else begin
			ref_state          <= next_ref_state;
			ref_count          <= next_ref_count;
			conv_was_on        <= analog_req.converter_on;
			converter_extended <= next_conv_ext;
		end
	end

	assign reference_ready = (ref_state == ref_ready);
	assign status = {5'h00, reference_ready, converter_extended, input_buffer_sleep_off};

	////////////////////////////////////////////////////////////////////////////////
	// Register side: what software writes must land, and nothing else may move the gates.
	AST_RSV_ZERO: assert property (
		peripheral_clock_gate[`BIT_RESERVED] == 1'b0
	) else $error("Reserved gate bit set.");

	AST_GATE_WRITE: assert property (
		(wr && sel(paddr, `GATE_REG_ADDR)) |=> peripheral_clock_gate == ($past(pwdata[7:0]) & `GATE_WRITE_MASK)
	) else $error("Gate register write lost.");

	AST_GATE_HOLD: assert property (
		!(wr && sel(paddr, `GATE_REG_ADDR)) |=> $stable(peripheral_clock_gate)
	) else $error("Gate register moved without a write.");

	AST_RSV_READ: assert property (
		(psel && !penable && sel(paddr, `GATE_REG_ADDR)) |=> prdata[31:8] == 24'h00_0000 && !prdata[`BIT_RESERVED]
	) else $error("Gate read shows reserved bits.");

	AST_CMP_WRITE: assert property (
		(wr && sel(paddr, `CMP_DIS_REG_ADDR)) |=> comparator_input_disable == $past(pwdata[CMP_PINS-1:0])
	) else $error("Comparator input disable write lost.");

	AST_CNV_WRITE: assert property (
		(wr && sel(paddr, `CNV_DIS_REG_ADDR)) |=> converter_input_disable == $past(pwdata[CNV_PINS-1:0])
	) else $error("Converter input disable write lost.");

	////////////////////////////////////////////////////////////////////////////////
	// Gating side: a gated unit neither ticks nor answers, an ungated one does both.
	AST_GATE_STOPS: assert property (
		peripheral_clock_gate[`BIT_SPI] |-> !unit_clock_en[`BIT_SPI] && !periph_access_ok[`BIT_SPI]
	) else $error("Gated unit still clocked.");

	AST_ACCESS_BLOCK: assert property (
		periph_access_ok[`BIT_USART] |-> !peripheral_clock_gate[`BIT_USART] && periph_access_req[`BIT_USART]
	) else $error("Access passed to gated unit.");

	AST_TIMER2_ASYNC: assert property (
		(timer_async_select && io_clock_en) |-> unit_clock_en[`BIT_TIMER2]
	) else $error("Async timer gated.");

	AST_TIMER2_SYNC: assert property (
		(peripheral_clock_gate[`BIT_TIMER2] && !timer_async_select) |-> !unit_clock_en[`BIT_TIMER2]
	) else $error("Synchronous timer still clocked.");

	AST_MUX_DENY: assert property (
		comparator_mux_allow != peripheral_clock_gate[`BIT_CONVERTER]
	) else $error("Mux allowed while gated.");

	// One copy per plain unit; the second timer and the reserved bit have their own checks.
	generate
		for (g = 0; g < `NUM_UNITS; g++) begin : g_check
			if (g != `BIT_TIMER2 && g != `BIT_RESERVED) begin : g_plain
				AST_UNIT_OFF: assert property (
					peripheral_clock_gate[g] |-> !unit_clock_en[g] && !periph_access_ok[g]
				) else $error("Gated unit still clocked or reachable.");
				AST_UNIT_OPEN: assert property (
					(!peripheral_clock_gate[g] && !sleeping) |-> unit_clock_en[g] && periph_access_ok[g] == periph_access_req[g]
				) else $error("Ungated unit not running.");
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Sleep side: which clocks run, and which pins keep their buffers.
	AST_DEEP_CMP: assert property (
		deep_sleep |-> !comparator_en && !unit_clock_en[`BIT_TWO_WIRE]
	) else $error("Comparator on in deep sleep.");

	AST_DEEP_STOP: assert property (
		deep_sleep |-> unit_clock_en == '0
	) else $error("Unit clocked in deep sleep.");

	AST_NOISE_CLK: assert property (
		noise_sleep |-> !io_clock_en && unit_clock_en[`NUM_UNITS-1:1] == '0
	) else $error("I/O units clocked in noise reduction.");

	AST_IDLE: assert property (
		idle_sleep |-> !cpu_clock_en && io_clock_en
	) else $error("Idle clocks wrong.");

	AST_IDLE_RUN: assert property (
		(idle_sleep && peripheral_clock_gate == `GATE_RESET) |-> unit_clock_en == {`NUM_UNITS{1'b1}}
	) else $error("Ungated unit stopped in idle.");

	AST_BUF_OFF: assert property (
		deep_sleep |-> input_buffer_sleep_off
	) else $error("Input buffers left on in deep sleep.");

	AST_BUF_ON: assert property (
		!deep_sleep |-> !input_buffer_sleep_off
	) else $error("Input buffers off while clocks run.");

	AST_DEBUG_OSC: assert property (
		debug_enable_fuse |-> main_osc_en
	) else $error("Main clock stopped under debug.");

	////////////////////////////////////////////////////////////////////////////////
	// Analog side: what stays on in sleep, and how the reference and converter restart.
	AST_CONV_KEEP: assert property (
		sleeping |-> converter_en == analog_req.converter_on
	) else $error("Converter dropped in sleep.");

	AST_WDOG_KEEP: assert property (
		sleeping |-> watchdog_en == analog_req.watchdog_on
	) else $error("Watchdog dropped in sleep.");

	AST_BOD_KEEP: assert property (
		(brownout_level_fuse != `BOD_DISABLED) |-> brownout_en && reference_en
	) else $error("Brown-out detector or its reference off.");

	AST_REF_HOLD: assert property (
		(analog_req.comparator_on && analog_req.comparator_uses_ref) |-> reference_en
	) else $error("Reference dropped.");

	AST_REF_OFF: assert property (
		!reference_en |=> !reference_ready
	) else $error("Reference ready while unused.");

	AST_REF_STAY: assert property (
		(reference_ready && reference_en) |=> reference_ready
	) else $error("Kept reference lost readiness.");

	AST_REF_WAIT: assert property (
		$rose(reference_en) |=> !reference_ready
	) else $error("Reference ready too soon.");

	AST_EXT_CONV: assert property (
		$rose(analog_req.converter_on) |=> converter_extended
	) else $error("No extended conversion.");

	AST_EXT_CLEAR: assert property (
		!analog_req.converter_on |=> !converter_extended
	) else $error("Extended flag kept while off.");

	COV_GATE_ALL: cover property (peripheral_clock_gate == `GATE_WRITE_MASK);
	COV_UNGATE: cover property ($fell(peripheral_clock_gate[`BIT_TIMER0]));
	COV_REF_READY: cover property ($rose(reference_ready));
	COV_BUF_OFF: cover property (input_buffer_sleep_off);
	COV_T2_ASYNC: cover property (peripheral_clock_gate[`BIT_TIMER2] && timer_async_select && io_clock_en);

endmodule : peripheral_clock_gating
`default_nettype wire

// ===== test/periph_model.sv
// Purpose: Far-side stand-in for the gated peripherals, one state counter per unit.
// Assumes: A unit's flops load only while its clock enable is high.
// Notes: Counters wrap at eight bits; the bench compares only differences.
`default_nettype none
module periph_model (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic [7:0]      unit_clock_en,
	output logic      [7:0][7:0] state
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0][7:0] next_state;
	////////////////////////////////////////////////////////////////////////////
	// A stopped unit must hold every bit, or a resume could not pick up where it left off.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			next_state[i] = unit_clock_en[i] ? 8'(state[i] + 8'h01) : state[i];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
endmodule : periph_model
`default_nettype wire

// ===== test/test_peripheral_clock_gating.sv
// Purpose: Self-checking bench for the peripheral clock gating block.
// Assumes: Zero-wait APB slave; reference start-up shortened to 4 cycles.
// Notes: Random stimulus from a fixed seed, with corner cases by hand.
`include "clock_gating_map.svh"
`default_nettype none
module test_peripheral_clock_gating;
	import clock_gating_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, err, sleeping;
	logic            timer_async_select, debug_enable_fuse, cpu_clock_en, io_clock_en, converter_clock_en;
	logic            main_osc_en, comparator_mux_allow, comparator_en, converter_en, converter_extended;
	logic            watchdog_en, brownout_en, reference_en, reference_ready, input_buffer_sleep_off;
	logic [2:0]      sleep_mode_select, brownout_level_fuse;
	logic [11:0]     paddr;
	logic [31:0]     pwdata, prdata, q;
	logic [1:0]      comparator_input_disable;
	logic [7:0]      periph_access_req, wake_pin_need, unit_clock_en, periph_access_ok, wake_buffer_en;
	logic [7:0]      converter_input_disable, v, e;
	logic [7:0][7:0] state, snap;
	analog_req_s     analog_req;
	int              seed = 39;
	int              n_mismatch = 0;
	int              tests_run = 0;
	int              cycles = 0;
	int              j;
	peripheral_clock_gating #(.REF_STARTUP_CYCLES(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sleeping, .sleep_mode_select, .timer_async_select,
		.debug_enable_fuse, .brownout_level_fuse, .analog_req, .periph_access_req, .wake_pin_need,
		.unit_clock_en, .periph_access_ok, .cpu_clock_en, .io_clock_en, .converter_clock_en, .main_osc_en,
		.comparator_mux_allow, .comparator_en, .converter_en, .converter_extended, .watchdog_en, .brownout_en,
		.reference_en, .reference_ready, .comparator_input_disable, .converter_input_disable,
		.input_buffer_sleep_off, .wake_buffer_en);
	periph_model pm (.pclk, .presetn, .unit_clock_en, .state);
	////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_mismatch++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Bit 4 has no unit behind it, so its enable is masked out of the enable compares; the unit state check expects it to count.
	function automatic logic [7:0] exp_en(input logic [7:0] g, input logic as);
		logic [7:0] r;
		r = ~g;
		r[6] = r[6] | as;
		return r & 8'hEF;
	endfunction : exp_en
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
		tests_run++;
		if (sn !== ex) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic conclude();
		$display("counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, paddr, pwdata, sleeping, sleep_mode_select, presetn} = '0;
		{timer_async_select, debug_enable_fuse, periph_access_req, wake_pin_need, analog_req} = '0;
		brownout_level_fuse = 3'h7;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `GATE_REG_ADDR, 32'h0000_0000);
		chk("gate at reset", 32'h0000_0000, q);
		for (int k = 0; k < 24; k++) begin
			v = (k == 0) ? 8'hFF : 8'($random(seed));
			@(posedge pclk);
			timer_async_select <= 1'($random(seed));
			periph_access_req <= 8'($random(seed));
			wake_pin_need <= 8'($random(seed));
			debug_enable_fuse <= k[1];
			v[2] = v[2] & !k[1];
			analog_req.converter_on <= 1'b0;
			apb(1'b1, `GATE_REG_ADDR, {24'h0000_00, v});
			apb(1'b0, `GATE_REG_ADDR, 32'h0000_0000);
			chk("gate readback", v & 8'hEF, q);
			@(negedge pclk);
			e = exp_en(v, timer_async_select);
			chk("clock enables", e, unit_clock_en & 8'hEF);
			chk("access ok", periph_access_req & e, periph_access_ok & 8'hEF);
			chk("mux allow", !v[0], comparator_mux_allow);
			snap = state;
			repeat (3) @(posedge pclk);
			@(negedge pclk);
			for (int i = 0; i < 8; i++) begin
				chk("unit state", 8'(snap[i] + ((e[i] || i == 4) ? 8'h03 : 8'h00)), state[i]);
			end
		end
		$display("test gating done");
		apb(1'b1, `GATE_REG_ADDR, 32'h0000_0000);
		@(posedge pclk);
		brownout_level_fuse <= 3'h4;
		analog_req <= 5'b01100;
		@(negedge pclk);
		chk("reference on", 1'b1, reference_en);
		chk("brownout fuse", 1'b1, brownout_en);
		for (j = 0; j < 20 && reference_ready !== 1'b1; j++) @(negedge pclk);
		chk("ref startup", 1'b1, j > 2 && j < 9);
		chk("extended", 1'b1, converter_extended);
		@(posedge pclk);
		analog_req.converter_on <= 1'b0;
		brownout_level_fuse <= 3'h7;
		repeat (2) @(negedge pclk);
		chk("extended off", 1'b0, converter_extended);
		chk("reference off", 1'b0, reference_en);
		$display("test analog done");
		for (int m = 0; m < 16; m++) begin
			@(posedge pclk);
			analog_req <= {2'b01, m[3], 2'b11};
			sleeping <= 1'b1;
			sleep_mode_select <= m[2:0];
			debug_enable_fuse <= m[3];
			repeat (2) @(negedge pclk);
			chk("cpu clock", 1'b0, cpu_clock_en);
			chk("io clock", m[2:0] == 0, io_clock_en);
			chk("adc clock", m[2:0] < 2, converter_clock_en);
			chk("main osc", m[2:0] < 2 || m[3], main_osc_en);
			chk("comparator", m[2:0] < 2, comparator_en);
			chk("buffers off", m[2:0] > 1, input_buffer_sleep_off);
			chk("wake buffers", wake_pin_need, wake_buffer_en);
			chk("converter kept", m[3], converter_en);
			chk("watchdog kept", 1'b1, watchdog_en);
			chk("reference kept", 1'b1, reference_en);
			e = (m[2:0] == 0) ? 8'hEF : ((m[2:0] == 1) ? 8'h01 : 8'h00);
			chk("idle gating", e, unit_clock_en & 8'hEF);
		end
		$display("test sleep done");
		v = 8'($random(seed));
		apb(1'b1, `CMP_DIS_REG_ADDR, {24'h0000_00, v});
		apb(1'b1, `CNV_DIS_REG_ADDR, {24'h0000_00, 8'(~v)});
		@(negedge pclk);
		chk("cmp disable", v[1:0], comparator_input_disable);
		chk("cnv disable", 8'(~v), converter_input_disable);
		apb(1'b1, 12'h010, 32'hFFFF_FFFF);
		chk("unmapped wr", 1'b1, err);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk("unmapped rd err", 1'b1, err);
		chk("unmapped rd data", 32'h0000_0000, q);
		apb(1'b1, `GATE_REG_ADDR, 32'h0000_00AF);
		apb(1'b0, `GATE_REG_ADDR, 32'h0000_0000);
		chk("gate before reset", 32'h0000_00AF, q);
		@(posedge pclk);
		presetn <= 1'b0;
		sleeping <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `GATE_REG_ADDR, 32'h0000_0000);
		chk("gate after reset", 32'h0000_0000, q);
		$display("test registers done");
		conclude();
	end
endmodule : test_peripheral_clock_gating
`default_nettype wire
